/* File: rtl/uart_serial_channel_one.sv */
// serial channel one: register slave, receiver, baud timer and transmitter
//
// Functional notes
// - eight-bit frame is start 0, eight data bits LSB first, stop 1.
// - eight-bit mode stores the received stop bit in the ninth-bit field.
// - a buffer write queues that byte; a later write before it starts replaces it.
// - reception starts on a start bit only while receive enable is set.
// - nine-bit mode receives nine data bits then stop; ninth bit is stored.
// - nine-bit frame is start, eight data LSB first, ninth bit, stop.
// - nine-bit transmitter sends the transmit-ninth-bit field as ninth data bit.
// - filter on in nine-bit mode: receive flag only when ninth bit is 1.
// - filter on in eight-bit mode: receive flag only with a high stop bit.
// - ninth-bit field holds ninth bit, or stop bit in eight-bit mode.
// - transmit flag set as the stop bit begins; cleared only by software.
// - receive flag set halfway through the stop bit; cleared only by software.
// - both flags are request outputs and stay readable for polling.
// - registers are byte wide; flags change only through whole-byte writes.
// - buffer write feeds the transmitter; buffer read returns a separate receive register.
// - baud timer is a free-running 8-bit up-counter at half the clock.
// - on overflow the baud timer reloads from the reload register.
// - the baud timer starts when software writes the reload register.
// - bit rate is clock divided by 32 times (256 minus reload).
// - frame is dropped if receive flag set or filter fails at final shift.
// - sixteen samples per bit; majority of states 7, 8, 9; bad start rejected.
`timescale 1ns/10ps
`include "uart1_cfg.svh"
module uart_serial_channel_one
  import uart1_pkg::*;
#(
  parameter int ADDR_WIDTH = 10
)
(
  input  wire logic                  CORE_CLK,            // 50 MHz core clock
  input  wire logic                  RST_N,               // async reset, active low
  input  wire logic [ADDR_WIDTH-1:0] AVS_ADDRESS,         // byte address
  input  wire logic                  AVS_READ,            // read request
  input  wire logic                  AVS_WRITE,           // write request
  input  wire logic [31:0]           AVS_WRITEDATA,       // write data, low byte used
  input  wire logic [3:0]            AVS_BYTEENABLE,      // lane 0 must be set to write
  output logic      [31:0]           AVS_READDATA,        // read data, upper bytes zero
  output logic                       AVS_WAITREQUEST,     // high while the request waits
  input  wire logic                  SERIAL_IN_LINE,      // receive line
  output logic                       SERIAL_OUT_LINE,     // transmit line
  output logic                       TRANSMIT_DONE_FLAG,  // transmit request level
  output logic                       RECEIVE_DONE_FLAG    // receive request level
);

  if (ADDR_WIDTH < 10)
  begin : g_addr_check
    $error("ADDR_WIDTH must hold the byte address of every register");
  end

  function automatic logic hits(input logic [ADDR_WIDTH-1:0] a, input logic [7:0] idx);
    hits = (a == ADDR_WIDTH'({idx, 2'b00}));
  endfunction

  function automatic logic majority(input logic a, input logic b, input logic c);
    majority = (a & b) | (a & c) | (b & c);
  endfunction

  channel_regs_type q;
  channel_regs_type d;

  logic       req;
  logic       wr_take;
  logic       wr_ctl;
  logic       wr_buf;
  logic       wr_rel;
  logic [7:0] wbyte;
  logic [7:0] ctl_view;
  logic       baud_tick;
  logic       tx_stop;
  logic       decide;
  logic       vote;
  logic       last_bit;
  logic       final_shift;
  logic       nine_val;
  logic       accept;

  // bus decode: each request waits exactly one cycle
  always_comb
  begin
    req      = AVS_READ | AVS_WRITE;
    wr_take  = AVS_WRITE & q.ack & AVS_BYTEENABLE[0];
    wbyte    = AVS_WRITEDATA[7:0];
    wr_ctl   = wr_take & hits(AVS_ADDRESS, `CTL_INDEX);
    wr_buf   = wr_take & hits(AVS_ADDRESS, `BUF_INDEX);
    wr_rel   = wr_take & hits(AVS_ADDRESS, `REL_INDEX);
    ctl_view = {q.fmt, 1'b0, q.mp, q.ren, q.tb8, q.rb8, q.ti, q.ri};
  end

  // receiver timing decode
  always_comb
  begin
    decide      = baud_tick && q.rxs == RX_BUSY && q.div == `VOTE_LAST;
    vote        = majority(q.votes[0], q.votes[1], q.sync2);
    last_bit    = (q.bitn == (q.fmt ? `LAST_BIT_8 : `LAST_BIT_9));
    final_shift = decide && last_bit;
    nine_val    = q.fmt ? vote : q.ninth;
    accept      = final_shift && !q.ri && (!q.mp || nine_val);
  end

  always_comb
  begin
    d     = q;
    d.ack = req & ~q.ack;
    if (req && !q.ack)
    begin
      if (hits(AVS_ADDRESS, `CTL_INDEX))
        d.rdata = ctl_view;
      else if (hits(AVS_ADDRESS, `BUF_INDEX))
        d.rdata = q.rx_buf;
      else if (hits(AVS_ADDRESS, `REL_INDEX))
        d.rdata = q.reload;
      else
        d.rdata = 8'h00;
    end

    if (wr_ctl)
    begin
      d.fmt = wbyte[`CTL_FMT_BIT];
      d.mp  = wbyte[`CTL_MP_BIT];
      d.ren = wbyte[`CTL_REN_BIT];
      d.tb8 = wbyte[`CTL_TB8_BIT];
      d.rb8 = wbyte[`CTL_RB8_BIT];
      d.ti  = wbyte[`CTL_TI_BIT];
      d.ri  = wbyte[`CTL_RI_BIT];
    end
    if (wr_rel)
      d.reload = wbyte;

    // hardware set wins over a software clear in the same cycle
    if (tx_stop)
      d.ti = 1'b1;

    // line synchroniser
    d.sync1 = SERIAL_IN_LINE;
    d.sync2 = q.sync1;
    d.prev  = q.sync2;

    unique case (q.rxs)
      RX_IDLE:
      begin
        if (q.ren && q.prev && !q.sync2)
        begin
          d.rxs  = RX_BUSY;
          d.div  = 4'h0;
          d.bitn = 4'h0;
        end
      end
      RX_BUSY:
      begin
        if (baud_tick)
        begin
          d.div = q.div + 4'h1;
          if (q.div == `VOTE_FIRST)
            d.votes[0] = q.sync2;
          if (q.div == `VOTE_MID)
            d.votes[1] = q.sync2;
          if (q.div == `DIV_LAST)
            d.bitn = q.bitn + 4'h1;
        end
        if (decide)
        begin
          if (q.bitn == 4'h0 && vote)
            d.rxs = RX_IDLE;
          else if (last_bit)
          begin
            d.rxs = RX_IDLE;
            if (accept)
            begin
              d.rx_buf = q.shift;
              d.rb8    = nine_val;
              d.ri     = 1'b1;
            end
          end
          else if (q.bitn == `NINTH_BIT_POS)
            d.ninth = vote;
          else if (q.bitn != 4'h0)
            d.shift = {vote, q.shift[7:1]};
        end
      end
      default:
      begin
        d.rxs = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      q       <= '0;
      q.sync1 <= 1'b1;
      q.sync2 <= 1'b1;
      q.prev  <= 1'b1;
    end
    else
      q <= d;
  end

  baud_reload_timer u_baud (
    .clk           (CORE_CLK),
    .rst_n         (RST_N),
    .reload_value  (d.reload),
    .reload_write  (wr_rel),
    .overflow_tick (baud_tick)
  );

  serial_frame_tx u_tx (
    .clk         (CORE_CLK),
    .rst_n       (RST_N),
    .tick16      (baud_tick),
    .load        (wr_buf),
    .load_data   (wbyte),
    .eight_bit   (q.fmt),
    .ninth_value (q.tb8),
    .line_out    (SERIAL_OUT_LINE),
    .stop_begin  (tx_stop)
  );

  assign AVS_WAITREQUEST    = req & ~q.ack;
  assign AVS_READDATA       = {24'h00_0000, q.rdata};
  assign TRANSMIT_DONE_FLAG = q.ti;
  assign RECEIVE_DONE_FLAG  = q.ri;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  sequence first_wait;
    req && AVS_WAITREQUEST;
  endsequence

  sequence answered;
    req && !AVS_WAITREQUEST;
  endsequence

  sequence frame_end_taken;
    accept ##1 RECEIVE_DONE_FLAG;
  endsequence

  sequence read_done;
    AVS_READ && !AVS_WAITREQUEST;
  endsequence

  sequence rx_start_seen;
    q.rxs == RX_IDLE && q.ren && q.prev && !q.sync2;
  endsequence

  AST_ONE_WAIT_CYCLE: assert property (first_wait |=> answered)
    else $error("request not answered on the second cycle");

  AST_BIT6_READS_ZERO: assert property
    (read_done ##0 hits(AVS_ADDRESS, `CTL_INDEX) |-> !AVS_READDATA[6])
    else $error("unused control bit read as one");

  AST_TI_ON_STOP: assert property (tx_stop |=> TRANSMIT_DONE_FLAG)
    else $error("transmit flag not set at the stop bit");

  AST_RI_ONLY_ON_ACCEPT: assert property
    ($rose(RECEIVE_DONE_FLAG) |-> $past(accept) || $past(wr_ctl))
    else $error("receive flag rose without an accepted frame");

  AST_FILTER_NINE: assert property
    (final_shift && q.mp && !q.fmt && !q.ninth && !wr_ctl
      |=> $stable(q.rx_buf) && $stable(q.rb8) && $stable(q.ri))
    else $error("address filter let a data frame through");

  AST_FILTER_STOP: assert property
    (final_shift && q.mp && q.fmt && !vote && !wr_ctl |=> $stable(q.ri))
    else $error("eight-bit filter accepted a bad stop bit");

  AST_STOP_TO_RB8: assert property
    (accept && q.fmt |-> frame_end_taken ##0 q.rb8 == $past(vote))
    else $error("stop bit not stored in the ninth-bit field");

  AST_DROP_WHEN_FULL: assert property
    (final_shift && q.ri && !wr_ctl |=> $stable(q.rx_buf) && RECEIVE_DONE_FLAG)
    else $error("frame overwrote an unread buffer");

  AST_REN_BLOCKS: assert property
    (q.rxs == RX_IDLE && !q.ren |=> q.rxs == RX_IDLE)
    else $error("reception started while disabled");

  AST_BAD_START: assert property
    (decide && q.bitn == 4'h0 && vote |=> q.rxs == RX_IDLE)
    else $error("false start bit not rejected");

  // bus answer checks: read data is the register as it stood in the wait cycle
  AST_BUF_READS_RX: assert property
    (read_done ##0 hits(AVS_ADDRESS, `BUF_INDEX) |-> AVS_READDATA[7:0] == $past(q.rx_buf))
    else $error("buffer read did not return the receive register");

  AST_REL_READS_BACK: assert property
    (read_done ##0 hits(AVS_ADDRESS, `REL_INDEX) |-> AVS_READDATA[7:0] == $past(q.reload))
    else $error("reload read did not return the reload register");

  AST_UNMAPPED_READS_ZERO: assert property
    (read_done ##0 !(hits(AVS_ADDRESS, `CTL_INDEX) || hits(AVS_ADDRESS, `BUF_INDEX)
                     || hits(AVS_ADDRESS, `REL_INDEX)) |-> AVS_READDATA == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");

  AST_REL_WRITE_LANDS: assert property
    (wr_rel |=> q.reload == $past(wbyte))
    else $error("reload write did not land");

  AST_LANE0_REQUIRED: assert property
    (AVS_WRITE && q.ack && !AVS_BYTEENABLE[0] |=> $stable(q.reload))
    else $error("write without low lane changed a register");

  // flag checks: hardware sets, only a control write clears
  AST_TI_HOLDS: assert property
    (TRANSMIT_DONE_FLAG && !wr_ctl |=> TRANSMIT_DONE_FLAG)
    else $error("transmit flag dropped without a control write");

  AST_RI_HOLDS: assert property
    (RECEIVE_DONE_FLAG && !wr_ctl |=> RECEIVE_DONE_FLAG)
    else $error("receive flag dropped without a control write");

  AST_TI_ONLY_ON_STOP: assert property
    ($rose(TRANSMIT_DONE_FLAG) |-> $past(tx_stop) || $past(wr_ctl))
    else $error("transmit flag rose without a stop bit");

  // receiver checks
  AST_START_ARMS: assert property
    (rx_start_seen |=> q.rxs == RX_BUSY && q.div == 4'h0 && q.bitn == 4'h0)
    else $error("start edge did not arm the receiver");

  AST_NINTH_TO_RB8: assert property
    (accept && !q.fmt |=> q.rb8 == $past(q.ninth))
    else $error("ninth bit not stored in the ninth-bit field");

  AST_BUF_ONLY_ON_ACCEPT: assert property
    (!accept |=> $stable(q.rx_buf))
    else $error("receive register changed without an accepted frame");

  AST_IDLE_AFTER_LAST: assert property
    (final_shift |=> q.rxs == RX_IDLE)
    else $error("receiver did not return to idle after the final shift");

  AST_BIT_BOUND: assert property
    (q.rxs == RX_BUSY |-> q.bitn <= `LAST_BIT_9)
    else $error("receive bit counter ran past the stop bit");

endmodule

/* File: rtl/uart1_cfg.svh */
// offsets, field positions, reset values and timing counts of serial channel one
`ifndef UART1_CFG_SVH
`define UART1_CFG_SVH

// register indexes; byte address is four times the index
`define CTL_INDEX        8'h9B
`define BUF_INDEX        8'h9C
`define REL_INDEX        8'h9D

// control/status field positions
`define CTL_FMT_BIT      7
`define CTL_MP_BIT       5
`define CTL_REN_BIT      4
`define CTL_TB8_BIT      3
`define CTL_RB8_BIT      2
`define CTL_TI_BIT       1
`define CTL_RI_BIT       0

// reset values
`define CTL_RESET        8'h00
`define BUF_RESET        8'h00
`define REL_RESET        8'h00

// timing counts
`define SAMPLES_PER_BIT  16
`define DIV_LAST         4'hF
`define VOTE_FIRST       4'h7
`define VOTE_MID         4'h8
`define VOTE_LAST        4'h9
`define FRAME_LEN_8      4'hA
`define FRAME_LEN_9      4'hB
`define LAST_BIT_8       4'h9
`define LAST_BIT_9       4'hA
`define NINTH_BIT_POS    4'h9
`define COUNT_TOP        8'hFF

`endif

/* File: rtl/uart1_pkg.sv */
// types shared by the serial channel one design
package uart1_pkg;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_BUSY = 2'b01
  } rx_state_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01
  } tx_phase_type;

  typedef struct packed {
    logic       half;
    logic       running;
    logic [7:0] count;
    logic       tick;
  } baud_regs_type;

  typedef struct packed {
    tx_phase_type phase;
    logic [3:0]   div;
    logic [10:0]  shift;
    logic [3:0]   left;
    logic         line;
    logic         stop_pulse;
    logic         pend;
    logic [10:0]  pend_frame;
    logic [3:0]   pend_len;
  } tx_regs_type;

  typedef struct packed {
    logic         fmt;
    logic         mp;
    logic         ren;
    logic         tb8;
    logic         rb8;
    logic         ti;
    logic         ri;
    logic [7:0]   rx_buf;
    logic [7:0]   reload;
    logic         ack;
    logic [7:0]   rdata;
    logic         sync1;
    logic         sync2;
    logic         prev;
    rx_state_type rxs;
    logic [3:0]   div;
    logic [3:0]   bitn;
    logic [1:0]   votes;
    logic [7:0]   shift;
    logic         ninth;
  } channel_regs_type;

endpackage

/* File: rtl/baud_reload_timer.sv */
// free-running 8-bit reload timer at half the core clock, one tick per overflow
`timescale 1ns/10ps
`include "uart1_cfg.svh"
module baud_reload_timer
  import uart1_pkg::*;
(
  input  wire logic       clk,           // core clock
  input  wire logic       rst_n,         // async reset, active low
  input  wire logic [7:0] reload_value,  // reload value being written
  input  wire logic       reload_write,  // software writes the reload register
  output logic            overflow_tick  // one-cycle pulse per overflow
);

  baud_regs_type q;
  baud_regs_type d;

  always_comb
  begin
    d      = q;
    d.tick = 1'b0;
    if (q.running)
    begin
      d.half = ~q.half;
      if (q.half)
      begin
        if (q.count == `COUNT_TOP)
        begin
          d.count = reload_value;
          d.tick  = 1'b1;
        end
        else
        begin
          d.count = q.count + 8'h01;
        end
      end
    end
    if (reload_write)
    begin
      d.running = 1'b1;
      d.count   = reload_value;
      d.half    = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign overflow_tick = q.tick;

  AST_RELOAD_ON_OVERFLOW: assert property (@(posedge clk) disable iff (!rst_n)
    (q.running && q.half && q.count == `COUNT_TOP && !reload_write)
      |=> (q.tick && q.count == $past(reload_value)))
    else $error("baud counter did not reload on overflow");

endmodule

/* File: rtl/serial_frame_tx.sv */
// transmitter: frames start on a divide-by-16 rollover, one bit per sixteen ticks
`timescale 1ns/10ps
`include "uart1_cfg.svh"
module serial_frame_tx
  import uart1_pkg::*;
(
  input  wire logic       clk,          // core clock
  input  wire logic       rst_n,        // async reset, active low
  input  wire logic       tick16,       // sixteen-times bit rate tick
  input  wire logic       load,         // buffer write, one-cycle pulse
  input  wire logic [7:0] load_data,    // byte to send
  input  wire logic       eight_bit,    // 1: ten-bit frame, 0: eleven-bit frame
  input  wire logic       ninth_value,  // ninth bit for eleven-bit frames
  output logic            line_out,     // serial output line
  output logic            stop_begin    // one-cycle pulse as the stop bit begins
);

  tx_regs_type q;
  tx_regs_type d;
  logic        roll;

  always_comb
  begin
    d            = q;
    d.stop_pulse = 1'b0;
    roll         = tick16 && (q.div == `DIV_LAST);
    if (tick16)
      d.div = q.div + 4'h1;
    if (roll)
    begin
      if (q.phase == TX_SEND && q.left != 4'h0)
      begin
        d.line       = q.shift[0];
        d.shift      = {1'b0, q.shift[10:1]};
        d.left       = q.left - 4'h1;
        d.stop_pulse = (q.left == 4'h1);
      end
      else if (q.pend)
      begin
        d.phase = TX_SEND;
        d.line  = q.pend_frame[0];
        d.shift = {1'b0, q.pend_frame[10:1]};
        d.left  = q.pend_len - 4'h1;
        d.pend  = 1'b0;
      end
      else
      begin
        d.phase = TX_IDLE;
        d.line  = 1'b1;
      end
    end
    if (load)
    begin
      d.pend       = 1'b1;
      d.pend_frame = eight_bit ? {2'b11, load_data, 1'b0}
                               : {1'b1, ninth_value, load_data, 1'b0};
      d.pend_len   = eight_bit ? `FRAME_LEN_8 : `FRAME_LEN_9;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q      <= '0;
      q.line <= 1'b1;
    end
    else
      q <= d;
  end

  assign line_out   = q.line;
  assign stop_begin = q.stop_pulse;

  AST_STOP_IS_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
    stop_begin |-> (line_out && q.left == 4'h0))
    else $error("stop pulse without a high stop bit on the line");

endmodule

/* File: test/remote_uart_model.sv */
// remote uart on the far end of the serial lines: sends frames on request, captures frames
`timescale 1ns/10ps
module remote_uart_model
#(
  parameter int BIT_CLKS = 32
)
(
  input  wire logic clk,       // core clock
  input  wire logic line_in,   // line driven by the channel
  input  wire logic nine_bit,  // 1: expect eleven-bit frames
  output logic      line_out   // line driven by this model, idle high
);
  logic [9:0] cap;
  logic [9:0] got_frame;
  int         got_count;

  initial
  begin
    line_out = 1'b1;
    got_count = 0;
    got_frame = 10'h000;
    cap = 10'h000;
  end

  // start 0, data lsb first, optional ninth bit, stop; a master marks addresses
  // with ninth bit 1 and data with 0
  task automatic send_frame(input logic [7:0] d, input logic nb, input logic ninth,
                            input logic stop);
    logic [10:0] f;
    f = nb ? {stop, ninth, d, 1'b0} : {1'b1, stop, d, 1'b0};
    for (int i = 0; i < (nb ? 11 : 10); i++)
    begin
      @(posedge clk);
      line_out <= f[i];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
    @(posedge clk);
    line_out <= 1'b1;
  endtask

  // short low pulse, far shorter than the sampling point of a start bit
  task automatic pulse_low(input int n);
    @(posedge clk);
    line_out <= 1'b0;
    repeat (n) @(posedge clk);
    line_out <= 1'b1;
  endtask

  // mid-bit sampling of each frame; result is {stop, ninth, data} or {0, stop, data}
  always
  begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < (nine_bit ? 10 : 9); i++)
    begin
      repeat (BIT_CLKS) @(posedge clk);
      cap = {line_in, cap[9:1]};
    end
    got_frame = nine_bit ? cap : {1'b0, cap[9:1]};
    got_count = got_count + 1;
  end
endmodule

/* File: test/uart_serial_channel_one_tb_top.sv */
// self-checking bench for serial channel one facing a remote uart model
`timescale 1ns/10ps
module uart_serial_channel_one_tb_top;
  localparam logic [9:0] CTL = 10'h26C;
  localparam logic [9:0] BUF = 10'h270;
  localparam logic [9:0] REL = 10'h274;

  typedef struct packed {
    logic [9:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_type;

  logic        clk;
  logic        rst_n;
  logic [9:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wdat;
  logic [3:0]  lane;
  logic [31:0] rdat;
  logic        waitreq;
  logic        rx_line;
  logic        tx_line;
  logic        tx_flag;
  logic        rx_flag;
  logic        nine;
  logic        wait_seen;
  logic [31:0] rdat_seen;
  logic [31:0] q;
  int          fail_count;
  int          check_count;
  int          n;
  int          c;
  row_type     rows [4] = '{'{CTL, 8'hFF, 8'hBF}, '{CTL, 8'h40, 8'h00},
                            '{10'h278, 8'h5A, 8'h00}, '{REL, 8'hFF, 8'hFF}};

  uart_serial_channel_one uart_serial_channel_one_inst
  (
    .CORE_CLK           (clk),
    .RST_N              (rst_n),
    .AVS_ADDRESS        (adr),
    .AVS_READ           (rd),
    .AVS_WRITE          (wr),
    .AVS_WRITEDATA      (wdat),
    .AVS_BYTEENABLE     (lane),
    .AVS_READDATA       (rdat),
    .AVS_WAITREQUEST    (waitreq),
    .SERIAL_IN_LINE     (rx_line),
    .SERIAL_OUT_LINE    (tx_line),
    .TRANSMIT_DONE_FLAG (tx_flag),
    .RECEIVE_DONE_FLAG  (rx_flag)
  );

  remote_uart_model remote_uart_model_inst
  (
    .clk      (clk),
    .line_in  (tx_line),
    .nine_bit (nine),
    .line_out (rx_line)
  );

  initial clk = 1'b0;
  always #10 clk = ~clk;

  // mid-cycle copies so the answer edge never races the design's updates
  always @(negedge clk)
  begin
    wait_seen = waitreq;
    rdat_seen = rdat;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    adr  <= a;
    wr   <= w;
    rd   <= !w;
    wdat <= {24'h00_0000, d};
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wait_seen !== 1'b0 && k < 20);
    q = rdat_seen;
    check("bus wait", 32'(wait_seen), 0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wreg(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rreg(input logic [9:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check("register read", q, {24'h00_0000, e});
  endtask

  task automatic wait_tx(input logic [9:0] exp);
    int k;
    k = remote_uart_model_inst.got_count;
    for (int t = 0; t < 2000 && remote_uart_model_inst.got_count == k; t++)
      @(posedge clk);
    check("line frame", {22'h0, remote_uart_model_inst.got_frame}, {22'h0, exp});
    check("line frame count", 32'(remote_uart_model_inst.got_count), 32'(k + 1));
  endtask

  task automatic wait_low;
    for (int t = 0; t < 2000 && tx_line !== 1'b0; t++)
      @(posedge clk);
  endtask

  task automatic send(input logic [7:0] d, input logic nb, input logic ninth, input logic stop);
    remote_uart_model_inst.send_frame(d, nb, ninth, stop);
  endtask

  initial
  begin
    #1_000_000;
    fail_count++;
    final_report;
  end

  initial
  begin
    rst_n = 1'b0;
    adr = 10'h000;
    rd = 1'b0;
    wr = 1'b0;
    wdat = 32'h0000_0000;
    lane = 4'hF;
    nine = 1'b1;
    fail_count = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rreg(CTL, 8'h00);
    rreg(BUF, 8'h00);
    rreg(REL, 8'h00);
    // timer idle until the reload write, so the frame waits
    wreg(BUF, 8'hA5);
    repeat (300) @(posedge clk);
    check("line idle", {31'h0, tx_line}, 1);
    wreg(REL, 8'hFF);
    wait_tx({2'b10, 8'hA5});
    foreach (rows[i])
    begin
      wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a, rows[i].e);
    end
    lane <= 4'hE;
    wreg(REL, 8'h12);
    lane <= 4'hF;
    rreg(REL, 8'hFF);
    nine = 1'b0;
    wreg(CTL, 8'h80);
    c = remote_uart_model_inst.got_count;
    wreg(BUF, 8'hA5);
    for (n = 0; n < 2000 && tx_flag !== 1'b1; n++)
      @(posedge clk);
    check("line at flag", {31'h0, tx_line}, 1);
    check("frame open", 32'(remote_uart_model_inst.got_count), c);
    wait_tx({2'b01, 8'hA5});
    rreg(CTL, 8'h82);
    wreg(CTL, 8'h80);
    @(negedge clk);
    check("tx flag", {31'h0, tx_flag}, 0);
    nine = 1'b1;
    for (int b = 0; b < 2; b++)
    begin
      wreg(CTL, {4'h0, b[0], 3'h0});
      wreg(BUF, 8'h3C);
      wait_low;
      wreg(BUF, 8'hC3);
      wait_tx({1'b1, b[0], 8'h3C});
      wait_tx({1'b1, b[0], 8'hC3});
    end
    nine = 1'b0;
    wreg(CTL, 8'h90);
    send(8'h5A, 1'b0, 1'b0, 1'b1);
    check("rx flag", {31'h0, rx_flag}, 1);
    rreg(BUF, 8'h5A);
    rreg(CTL, 8'h95);
    send(8'h11, 1'b0, 1'b0, 1'b1);
    rreg(BUF, 8'h5A);
    wreg(CTL, 8'hB0);
    send(8'h66, 1'b0, 1'b0, 1'b0);
    check("rx flag", {31'h0, rx_flag}, 0);
    rreg(BUF, 8'h5A);
    wreg(CTL, 8'h30);
    send(8'h22, 1'b1, 1'b0, 1'b1);
    check("rx flag", {31'h0, rx_flag}, 0);
    send(8'h33, 1'b1, 1'b1, 1'b1);
    check("rx flag", {31'h0, rx_flag}, 1);
    rreg(BUF, 8'h33);
    rreg(CTL, 8'h35);
    wreg(CTL, 8'h00);
    send(8'h44, 1'b1, 1'b1, 1'b1);
    check("rx flag", {31'h0, rx_flag}, 0);
    rreg(BUF, 8'h33);
    wreg(CTL, 8'h90);
    remote_uart_model_inst.pulse_low(4);
    repeat (400) @(posedge clk);
    check("rx flag", {31'h0, rx_flag}, 0);
    send(8'h77, 1'b0, 1'b0, 1'b1);
    check("rx flag", {31'h0, rx_flag}, 1);
    rreg(BUF, 8'h77);
    wreg(CTL, 8'h80);
    wreg(REL, 8'hFE);
    wreg(BUF, 8'h01);
    wait_low;
    for (n = 0; n < 2000 && tx_line === 1'b0; n++)
      @(posedge clk);
    check("start bit clocks", n, 64);
    final_report;
  end
endmodule
